// File: hdl/otp_group_a.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
// What this block does
// - xor enable set: xor each conversion result
// - xor enable clear: result passes unchanged
// - xor source ignored while xor disabled
// - source zero: append prbs bit, xor with it
// - source one: xor result with own lsb
// - pattern enable picks result or test pattern
// - mode 0 or 1: first fixed pattern
// - mode 2: digital ramp output
// - mode 3: alternate first and second pattern
// - ramp step is increment field plus one
// - first pattern low 16 bits at 14h
// - first pattern high byte at 15h low
// - second pattern low byte at 15h high
// - second pattern high 16 bits at 16h
module otp_group_a
  import otp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [PAT_W-1:0] sampleData,
  output logic outValid,
  input wire logic outReady,
  output otp_word_type outWord
);

  // register file
  logic [REG_W-1:0] xorCtrl_q;
  logic [REG_W-1:0] patCtrl_q;
  logic [REG_W-1:0] pat0Low_q;
  logic [REG_W-1:0] patMix_q;
  logic [REG_W-1:0] pat1High_q;

  // bus pipeline
  logic wrPend_q;
  logic [7:0] wrIdx_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  // pattern state
  logic [PAT_W-1:0] ramp_q;
  logic rampWas_q;
  logic altPhase_q;
  logic altWas_q;
  logic [PRBS_W-1:0] prbs_q;

  // two-entry buffer
  otp_word_type head_q;
  otp_word_type tail_q;
  logic headValid_q;
  logic tailValid_q;
  logic sampleReady_q;

  // address decode
  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] reqIdx = haddr[9:2];
  wire addrInRange = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
  wire wrNow = ce && wrPend_q;

  wire [REG_W-1:0] wrWord = hwdata[REG_W-1:0];
  wire wrXor = wrNow && (wrIdx_q == IDX_XOR_CTRL);
  wire wrPatCtrl = wrNow && (wrIdx_q == IDX_PAT_CTRL);
  wire wrPat0Low = wrNow && (wrIdx_q == IDX_PAT0_LOW);
  wire wrPatMix = wrNow && (wrIdx_q == IDX_PAT_MIX);
  wire wrPat1High = wrNow && (wrIdx_q == IDX_PAT1_HIGH);

  // register view after any write now in its data phase, so a read right
  // behind a write to the same word sees the new value
  wire [REG_W-1:0] xorView = wrXor ? wrWord : xorCtrl_q;
  wire [REG_W-1:0] patCtrlView = wrPatCtrl ? wrWord : patCtrl_q;
  wire [REG_W-1:0] pat0LowView = wrPat0Low ? wrWord : pat0Low_q;
  wire [REG_W-1:0] patMixView = wrPatMix ? wrWord : patMix_q;
  wire [REG_W-1:0] pat1HighView = wrPat1High ? wrWord : pat1High_q;

  wire [REG_W-1:0] rdSel =
    !addrInRange ? 16'h0000 :
    (reqIdx == IDX_XOR_CTRL) ? xorView :
    (reqIdx == IDX_PAT_CTRL) ? patCtrlView :
    (reqIdx == IDX_PAT0_LOW) ? pat0LowView :
    (reqIdx == IDX_PAT_MIX) ? patMixView :
    (reqIdx == IDX_PAT1_HIGH) ? pat1HighView :
    16'h0000;

  // control fields
  wire xorEnable = xorCtrl_q[XOR_EN_BIT];
  wire xorSourceSelect = xorCtrl_q[XOR_SRC_BIT];
  wire patternEnableGroupA = patCtrl_q[PAT_EN_BIT];
  wire [1:0] patternModeGroupA = patCtrl_q[PAT_MODE_LSB +: 2];
  wire [INC_W-1:0] rampIncrement = patCtrl_q[RAMP_INC_LSB +: INC_W];

  // fixed patterns assembled from their register pieces
  wire [PAT_W-1:0] fixedPatternFirstGroupA = {patMix_q[7:0], pat0Low_q};
  wire [PAT_W-1:0] fixedPatternSecondGroupA = {pat1High_q, patMix_q[15:8]};

  // pattern source
  otp_src_type src;
  always_comb
  begin
    src = SRC_RESULT;
    if (patternEnableGroupA)
    begin
      case (patternModeGroupA)
        MODE_FIXED_A: src = SRC_FIXED;
        MODE_FIXED_B: src = SRC_FIXED;
        MODE_RAMP: src = SRC_RAMP;
        MODE_ALT: src = SRC_ALT;
        default: src = SRC_FIXED;
      endcase
    end
  end

  wire rampActive = (src == SRC_RAMP);
  wire altActive = (src == SRC_ALT);
  wire rampEntry = rampActive && !rampWas_q;
  wire altEntry = altActive && !altWas_q;
  wire [PAT_W-1:0] rampNow = rampEntry ? 24'h000000 : ramp_q;
  wire altNow = altEntry ? 1'b0 : altPhase_q;
  wire [PAT_W-1:0] rampStep = {{(PAT_W-INC_W){1'b0}}, rampIncrement} + 24'h000001;

  // xor of the conversion result
  wire prbsBit = prbs_q[PRBS_W-1];
  wire xorBit = xorSourceSelect ? sampleData[0] : prbsBit;
  wire [PAT_W-1:0] xorResult = sampleData ^ {PAT_W{xorBit}};
  wire [PAT_W-1:0] resultOut = xorEnable ? xorResult : sampleData;
  wire prbsAppend = xorEnable && !xorSourceSelect;

  otp_word_type newWord;
  always_comb
  begin
    newWord.prbsBit = 1'b0;
    newWord.prbsOn = 1'b0;
    case (src)
      SRC_RESULT:
      begin
        newWord.data = resultOut;
        newWord.prbsOn = prbsAppend;
        newWord.prbsBit = prbsAppend ? prbsBit : 1'b0;
      end
      SRC_FIXED: newWord.data = fixedPatternFirstGroupA;
      SRC_RAMP: newWord.data = rampNow;
      SRC_ALT: newWord.data = altNow ? fixedPatternSecondGroupA : fixedPatternFirstGroupA;
      default: newWord.data = sampleData;
    endcase
  end

  // buffer handshakes
  wire push = sampleValid && sampleReady_q;
  wire pop = headValid_q && outReady;

  logic headValid_d;
  logic tailValid_d;
  otp_word_type head_d;
  otp_word_type tail_d;
  always_comb
  begin
    headValid_d = headValid_q;
    tailValid_d = tailValid_q;
    head_d = head_q;
    tail_d = tail_q;
    if (tailValid_q)
    begin
      if (pop)
      begin
        head_d = tail_q;
        tailValid_d = 1'b0;
      end
    end
    else if (headValid_q)
    begin
      if (pop && push)
        head_d = newWord;
      else if (pop)
        headValid_d = 1'b0;
      else if (push)
      begin
        tail_d = newWord;
        tailValid_d = 1'b1;
      end
    end
    else if (push)
    begin
      head_d = newWord;
      headValid_d = 1'b1;
    end
  end

  // prbs next state
  wire [PRBS_W-1:0] prbsNext = {prbs_q[PRBS_W-2:0], prbs_q[14] ^ prbs_q[13]};

  // registers; reserved bits are stored as written, software keeps them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      xorCtrl_q <= RST_XOR_CTRL;
      patCtrl_q <= RST_PAT_CTRL;
      pat0Low_q <= RST_PAT0_LOW;
      patMix_q <= RST_PAT_MIX;
      pat1High_q <= RST_PAT1_HIGH;
    end
    else
    begin
      xorCtrl_q <= xorView;
      patCtrl_q <= patCtrlView;
      pat0Low_q <= pat0LowView;
      patMix_q <= patMixView;
      pat1High_q <= pat1HighView;
    end
  end

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout_q <= 1'b1;
      wrPend_q <= addrPhase && hwrite && addrInRange;
      wrIdx_q <= reqIdx;
      if (addrPhase && !hwrite)
        hrdata_q <= {16'h0000, rdSel};
    end
  end

  // pattern sequencing, advances once per accepted sample
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ramp_q <= 24'h000000;
      rampWas_q <= 1'b0;
      altPhase_q <= 1'b0;
      altWas_q <= 1'b0;
      prbs_q <= PRBS_SEED;
    end
    else if (ce)
    begin
      rampWas_q <= rampActive;
      altWas_q <= altActive;
      if (rampEntry)
        ramp_q <= push ? rampStep : 24'h000000;
      else if (push && rampActive)
        ramp_q <= ramp_q + rampStep;
      if (altEntry)
        altPhase_q <= push;
      else if (push && altActive)
        altPhase_q <= !altPhase_q;
      if (push)
        prbs_q <= prbsNext;
    end
  end

  // two-entry buffer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      head_q <= '0;
      tail_q <= '0;
      headValid_q <= 1'b0;
      tailValid_q <= 1'b0;
      sampleReady_q <= 1'b0;
    end
    else if (ce)
    begin
      head_q <= head_d;
      tail_q <= tail_d;
      headValid_q <= headValid_d;
      tailValid_q <= tailValid_d;
      sampleReady_q <= !tailValid_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign sampleReady = sampleReady_q;
  assign outValid = headValid_q;
  assign outWord = head_q;

endmodule

// File: hdl/otp_pkg.sv
package otp_pkg;

  localparam int unsigned PAT_W = 24;
  localparam int unsigned REG_W = 16;
  localparam int unsigned INC_W = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_XOR_CTRL = 8'h12;
  localparam logic [7:0] IDX_PAT_CTRL = 8'h13;
  localparam logic [7:0] IDX_PAT0_LOW = 8'h14;
  localparam logic [7:0] IDX_PAT_MIX = 8'h15;
  localparam logic [7:0] IDX_PAT1_HIGH = 8'h16;

  localparam logic [15:0] RST_XOR_CTRL = 16'h0002;
  localparam logic [15:0] RST_PAT_CTRL = 16'h0000;
  localparam logic [15:0] RST_PAT0_LOW = 16'h0000;
  localparam logic [15:0] RST_PAT_MIX = 16'h0000;
  localparam logic [15:0] RST_PAT1_HIGH = 16'h0000;

  // field positions
  localparam int unsigned XOR_EN_BIT = 3;
  localparam int unsigned XOR_SRC_BIT = 4;
  localparam int unsigned PAT_EN_BIT = 1;
  localparam int unsigned PAT_MODE_LSB = 2;
  localparam int unsigned RAMP_INC_LSB = 4;

  localparam logic [1:0] MODE_FIXED_A = 2'h0;
  localparam logic [1:0] MODE_FIXED_B = 2'h1;
  localparam logic [1:0] MODE_RAMP = 2'h2;
  localparam logic [1:0] MODE_ALT = 2'h3;

  // pseudo-random source: x^15 + x^14 + 1
  localparam int unsigned PRBS_W = 15;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;

  typedef enum logic [1:0] {SRC_RESULT, SRC_FIXED, SRC_RAMP, SRC_ALT} otp_src_type;

  typedef struct packed {
    logic [PAT_W-1:0] data;
    logic prbsBit;
    logic prbsOn;
  } otp_word_type;

endpackage

// File: bench/otp_group_a_checker.sv
`timescale 1ns/10ps
module otp_group_a_checker
  import otp_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic ce,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input logic sampleValid,
  input logic sampleReady,
  input logic [PAT_W-1:0] sampleData,
  input logic outValid,
  input logic outReady,
  input otp_word_type outWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_q;
  logic [7:0] idx_q;
  logic [15:0] xc_q;
  logic [15:0] pc_q;
  // a take into an empty buffer shows up one cycle later
  wire take = sampleValid && sampleReady && !outValid && ce;
  wire plain = take && !pc_q[PAT_EN_BIT];
  always_ff @(posedge clk)
  begin
    if (ce || !rst_n)
    begin
      wr_q <= rst_n && hsel && htrans[1] && hready && hwrite;
      idx_q <= haddr[9:2];
      xc_q <= !rst_n ? RST_XOR_CTRL : (wr_q && idx_q == IDX_XOR_CTRL) ? hwdata[15:0] : xc_q;
      pc_q <= !rst_n ? RST_PAT_CTRL : (wr_q && idx_q == IDX_PAT_CTRL) ? hwdata[15:0] : pc_q;
    end
  end
  plain_pass_a: assert property (plain && !xc_q[3] |=> outWord.data == $past(sampleData) && !outWord.prbsOn)
    else $error("result altered with xor off");
  prbs_mix_a: assert property (plain && xc_q[3] && !xc_q[4] |=> outWord.prbsOn &&
    outWord.data == ($past(sampleData) ^ {PAT_W{outWord.prbsBit}})) else $error("random bit mix wrong");
  lsb_mix_a: assert property (plain && xc_q[3] && xc_q[4] |=>
    outWord.data == ($past(sampleData) ^ {PAT_W{$past(sampleData[0])}})) else $error("lsb mix wrong");
  pattern_gate_a: assert property (take && pc_q[1] |=> !outWord.prbsOn)
    else $error("random bit on pattern");
  valid_next_a: assert property (take |=> outValid) else $error("word not presented");
  out_hold_a: assert property (outValid && !outReady && ce |=> outValid && $stable(outWord))
    else $error("word dropped while stalled");
  ready_up_a: assert property (rst_n && ce |=> hreadyout) else $error("bus wait state");
  okay_resp_a: assert property (hresp == 1'b0 && hrdata[31:16] == 16'h0) else $error("bad response or upper half");
  cover property (take && pc_q[1]);
  cover property (sampleValid && !sampleReady);
  cover property (plain && xc_q[3] && !xc_q[4]);
endmodule
bind otp_group_a otp_group_a_checker CHK (.clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .sampleValid, .sampleReady, .sampleData, .outValid, .outReady, .outWord);

// File: bench/otp_sink.sv
`timescale 1ns/10ps
module otp_sink
  import otp_pkg::*;
(
  input logic clk,
  input logic stall,
  input logic outValid,
  input otp_word_type outWord,
  output logic outReady
);
  otp_word_type got[$];
  initial outReady = 1'b0;
  // registered ready, so a stall takes effect one cycle late
  always @(posedge clk)
  begin
    if (outValid && outReady)
      got.push_back(outWord);
    outReady <= !stall;
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb
  import otp_pkg::*;
;
  typedef struct packed {logic [15:0] xc; logic [15:0] pc; logic [23:0] s; logic [23:0] ed; logic po;} otp_row_type;
  localparam otp_row_type ROWS [6] = '{{16'h0002, 16'h0000, 24'h123456, 24'h123456, 1'b0},
    {16'h0012, 16'h0000, 24'habcdef, 24'habcdef, 1'b0}, {16'h001a, 16'h0000, 24'habcdef, 24'h543210, 1'b0},
    {16'h000a, 16'h0000, 24'h00f00f, 24'h00f00f, 1'b1}, {16'h000a, 16'h0002, 24'h111111, 24'h345678, 1'b0},
    {16'h0002, 16'h0006, 24'h222222, 24'h345678, 1'b0}};
  logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, sampleValid = 1'b0, stall = 1'b0;
  logic hreadyout, hresp, sampleReady, outValid, outReady;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [23:0] sampleData = 24'h0;
  otp_word_type outWord, w;
  int errors = 0, cmp_count = 0;
  otp_group_a DUT (.clk, .rst_n, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sampleValid, .sampleReady, .sampleData, .outValid,
    .outReady, .outWord);
  otp_sink SNK (.clk, .stall, .outValid, .outWord, .outReady);
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ix, input logic [15:0] wd, output logic [31:0] rv);
    haddr <= {22'h0, ix, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic push(input logic [23:0] d);
    sampleValid <= 1'b1;
    sampleData <= d;
    do @(posedge clk); while (sampleReady !== 1'b1);
  endtask
  task automatic pull(input logic [24:0] e, input logic mix);
    int n;
    n = 0;
    while (SNK.got.size() == 0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    w = (SNK.got.size() != 0) ? SNK.got.pop_front() : '1;
    // the appended bit steps once per accepted sample, so only its consistency is judged
    if (mix)
      e[24:1] = e[24:1] ^ {24{w.prbsBit}};
    chk({7'h0, w.data, w.prbsOn}, {7'h0, e});
  endtask
  task automatic seq(input logic [15:0] pc, input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
    bus(1'b1, IDX_PAT_CTRL, pc, rd);
    push(24'h0);
    push(24'h0);
    push(24'h0);
    sampleValid <= 1'b0;
    pull({a, 1'b0}, 1'b0);
    pull({b, 1'b0}, 1'b0);
    pull({c, 1'b0}, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    chk({31'h0, hreadyout}, 32'h0);
    chk({31'h0, sampleReady}, 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, IDX_XOR_CTRL, 16'h0, rd);
    chk(rd, 32'h2);
    bus(1'b0, IDX_PAT_CTRL, 16'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, 8'h10, 16'hffff, rd);
    bus(1'b0, 8'h10, 16'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, IDX_PAT0_LOW, 16'h5678, rd);
    bus(1'b1, IDX_PAT_MIX, 16'h9a34, rd);
    bus(1'b1, IDX_PAT1_HIGH, 16'hbcde, rd);
    bus(1'b0, IDX_PAT_MIX, 16'h0, rd);
    chk(rd, 32'h9a34);
    foreach (ROWS[i])
    begin
      bus(1'b1, IDX_XOR_CTRL, ROWS[i].xc, rd);
      bus(1'b1, IDX_PAT_CTRL, ROWS[i].pc, rd);
      push(ROWS[i].s);
      sampleValid <= 1'b0;
      pull({ROWS[i].ed, ROWS[i].po}, ROWS[i].po);
    end
    seq(16'h003a, 24'h0, 24'h4, 24'h8);
    seq(16'h000e, 24'h345678, 24'hbcde9a, 24'h345678);
    seq(16'h00fa, 24'h0, 24'h10, 24'h20);
    bus(1'b1, IDX_PAT_CTRL, 16'h0, rd);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    push(24'h1);
    push(24'h2);
    sampleData <= 24'h3;
    repeat (2) @(posedge clk);
    chk({31'h0, sampleReady}, 32'h0);
    stall <= 1'b0;
    push(24'h3);
    sampleValid <= 1'b0;
    pull({24'h1, 1'b0}, 1'b0);
    pull({24'h2, 1'b0}, 1'b0);
    pull({24'h3, 1'b0}, 1'b0);
    end_of_test;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    end_of_test;
  end
endmodule
